// ---- design/wcsp_params.svh ----
// constants for the window crop, scale and place stage
// assumes one 25 MHz clock and 12-bit pixel coordinates
`ifndef WCSP_PARAMS_SVH
`define WCSP_PARAMS_SVH

// ----------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------
`define WCSP_NUM_INPUTS 4
`define WCSP_ID_W       2
`define WCSP_COORD_W    12
`define WCSP_DST_W      13
`define WCSP_POS_W      14
`define WCSP_PIX_W      24

// ----------------------------------------------------------------
// reset values of every source and destination window
// ----------------------------------------------------------------
`define WCSP_SRC_LEFT_RST   12'h000
`define WCSP_SRC_TOP_RST    12'h000
`define WCSP_SRC_WIDTH_RST  12'h280
`define WCSP_SRC_HEIGHT_RST 12'h1E0
`define WCSP_DST_LEFT_RST   13'h0000
`define WCSP_DST_TOP_RST    13'h0000
`define WCSP_DST_WIDTH_RST  12'h280
`define WCSP_DST_HEIGHT_RST 12'h1E0

`endif

// ---- design/wcsp_pkg.sv ----
// types shared by the window crop, scale and place stage
// assumes wcsp_params.svh sits beside it
`include "wcsp_params.svh"

package wcsp_pkg;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`WCSP_PIX_W-1:0] data;
    logic                   sof;
    logic                   eol;
    logic [`WCSP_ID_W-1:0]  id;
  } wcsp_pix_t;

  typedef struct packed {
    logic [`WCSP_COORD_W-1:0] left;
    logic [`WCSP_COORD_W-1:0] top;
    logic [`WCSP_COORD_W-1:0] width;
    logic [`WCSP_COORD_W-1:0] height;
  } wcsp_src_rect_t;

  typedef struct packed {
    logic signed [`WCSP_DST_W-1:0] left;
    logic signed [`WCSP_DST_W-1:0] top;
    logic [`WCSP_COORD_W-1:0]      width;
    logic [`WCSP_COORD_W-1:0]      height;
  } wcsp_dst_rect_t;

  typedef struct packed {
    logic [`WCSP_COORD_W-1:0] x;
    logic [`WCSP_COORD_W-1:0] y;
    logic [`WCSP_PIX_W-1:0]   data;
  } wcsp_out_t;

  typedef enum logic [1:0] {
    WCSP_TAKE = 2'b00,
    WCSP_VCNT = 2'b01,
    WCSP_EMIT = 2'b10
  } wcsp_state_t;

endpackage

// ---- design/wcsp_top.sv ----
// window crop, scale and place stage: input pixel stream in, screen writes out
// assumes same-clock stream and settings ports; output feeds a frame store
`timescale 1ns/1ps
`default_nettype none
`include "wcsp_params.svh"

module wcsp_top (
  input  wire logic                     REF_CLK,
  input  wire logic                     SRST,
  input  wire logic [`WCSP_ID_W-1:0]    SEL_INPUT,
  input  wire logic                     SET_SOURCE_WINDOW,
  input  wire wcsp_pkg::wcsp_src_rect_t SRC_WIN_IN,
  input  wire logic                     SET_DESTINATION_WINDOW,
  input  wire wcsp_pkg::wcsp_dst_rect_t DST_WIN_IN,
  input  wire logic [`WCSP_COORD_W-1:0] SCREEN_W,
  input  wire logic [`WCSP_COORD_W-1:0] SCREEN_H,
  input  wire logic                     IN_VALID,
  input  wire wcsp_pkg::wcsp_pix_t      IN_PIX,
  output logic                          IN_READY,
  output logic                          OUT_VALID,
  output wcsp_pkg::wcsp_out_t           OUT_PIX,
  input  wire logic                     OUT_READY
);
  import wcsp_pkg::*;

  // ----------------------------------------------------------------
  // per-input window tables
  // ----------------------------------------------------------------
  wcsp_src_rect_t src_tab_q [`WCSP_NUM_INPUTS];
  wcsp_src_rect_t src_tab_d [`WCSP_NUM_INPUTS];
  wcsp_dst_rect_t dst_tab_q [`WCSP_NUM_INPUTS];
  wcsp_dst_rect_t dst_tab_d [`WCSP_NUM_INPUTS];

  // a setting only lands in the selected input's slot
  always_comb begin
    for (int i = 0; i < `WCSP_NUM_INPUTS; i++) begin
      src_tab_d[i] = src_tab_q[i];
      dst_tab_d[i] = dst_tab_q[i];
      if (SET_SOURCE_WINDOW && SEL_INPUT == i[`WCSP_ID_W-1:0]) begin
        src_tab_d[i] = SRC_WIN_IN;
      end
      if (SET_DESTINATION_WINDOW && SEL_INPUT == i[`WCSP_ID_W-1:0]) begin
        dst_tab_d[i] = DST_WIN_IN;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    for (int i = 0; i < `WCSP_NUM_INPUTS; i++) begin
      if (SRST) begin
        src_tab_q[i] <= '{`WCSP_SRC_LEFT_RST, `WCSP_SRC_TOP_RST, `WCSP_SRC_WIDTH_RST, `WCSP_SRC_HEIGHT_RST};
        dst_tab_q[i] <= '{`WCSP_DST_LEFT_RST, `WCSP_DST_TOP_RST, `WCSP_DST_WIDTH_RST, `WCSP_DST_HEIGHT_RST};
      end else begin
        src_tab_q[i] <= src_tab_d[i];
        dst_tab_q[i] <= dst_tab_d[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // crop and scale engine
  // ----------------------------------------------------------------
  wcsp_state_t               state_q, state_d;
  wcsp_src_rect_t            fsrc_q, fsrc_d;
  wcsp_dst_rect_t            fdst_q, fdst_d;
  logic [`WCSP_COORD_W-1:0]  sx_q, sx_d, sy_q, sy_d;
  logic [`WCSP_PIX_W-1:0]    pix_q, pix_d;
  logic [`WCSP_DST_W-1:0]    hacc_q, hacc_d, vacc_q, vacc_d;
  logic [`WCSP_DST_W-1:0]    vwork_q, vwork_d, rows_q, rows_d, r_q, r_d;
  logic signed [`WCSP_POS_W-1:0] dx_q, dx_d, dy_q, dy_d, y0_q, y0_d;
  logic                      rdy_q, rdy_d;
  logic                      push;
  wcsp_out_t                 push_pix;
  logic                      fifo_full;

  // locals of the engine
  wcsp_src_rect_t            fs;
  wcsp_dst_rect_t            fd;
  logic [`WCSP_COORD_W-1:0]  cur_x, cur_y;
  logic                      in_win, take;
  logic signed [`WCSP_POS_W-1:0] oy;
  logic                      vis;

  // one source pixel spawns a block of screen pixels; the input stalls meanwhile
  always_comb begin
    state_d = state_q;
    fsrc_d  = fsrc_q;
    fdst_d  = fdst_q;
    sx_d    = sx_q;
    sy_d    = sy_q;
    pix_d   = pix_q;
    hacc_d  = hacc_q;
    vacc_d  = vacc_q;
    vwork_d = vwork_q;
    rows_d  = rows_q;
    r_d     = r_q;
    dx_d    = dx_q;
    dy_d    = dy_q;
    y0_d    = y0_q;
    push    = 1'b0;
    fs      = IN_PIX.sof ? src_tab_q[IN_PIX.id] : fsrc_q;
    fd      = IN_PIX.sof ? dst_tab_q[IN_PIX.id] : fdst_q;
    cur_x   = IN_PIX.sof ? '0 : sx_q;
    cur_y   = IN_PIX.sof ? '0 : sy_q;
    // inclusive bottom-right is left+width-1 and top+height-1
    in_win  = (cur_x >= fs.left) && ((cur_x - fs.left) < fs.width) &&
              (cur_y >= fs.top) && ((cur_y - fs.top) < fs.height) &&
              (fd.width != '0) && (fd.height != '0);
    take    = (state_q == WCSP_TAKE) && rdy_q && IN_VALID;
    oy      = y0_q + $signed({1'b0, r_q});
    vis     = (dx_q >= 0) && (dx_q < $signed({2'b00, SCREEN_W})) &&
              (oy >= 0) && (oy < $signed({2'b00, SCREEN_H}));
    push_pix = '{dx_q[`WCSP_COORD_W-1:0], oy[`WCSP_COORD_W-1:0], pix_q};
    unique case (state_q)
      WCSP_TAKE: begin
        if (take) begin
          if (IN_PIX.sof) begin
            fsrc_d = fs; // window frozen for the whole frame
            fdst_d = fd;
          end
          sx_d = IN_PIX.eol ? '0 : cur_x + 1'b1;
          sy_d = IN_PIX.eol ? cur_y + 1'b1 : cur_y;
          if (in_win) begin
            pix_d = IN_PIX.data;
            if (cur_x == fs.left) begin
              // first pixel of a used row: work out its screen row count
              hacc_d  = {1'b0, fd.width};
              dx_d    = {fd.left[`WCSP_DST_W-1], fd.left};
              vwork_d = ((cur_y == fs.top) ? '0 : vacc_q) + {1'b0, fd.height};
              if (cur_y == fs.top) begin
                dy_d = {fd.top[`WCSP_DST_W-1], fd.top};
              end
              rows_d  = '0;
              state_d = WCSP_VCNT;
            end else begin
              hacc_d  = hacc_q + {1'b0, fd.width};
              state_d = WCSP_EMIT;
            end
            r_d = '0;
          end
        end
      end
      WCSP_VCNT: begin
        // repeated subtraction instead of a divider; costs one cycle per row
        if (vwork_q >= {1'b0, fsrc_q.height}) begin
          vwork_d = vwork_q - {1'b0, fsrc_q.height};
          rows_d  = rows_q + 1'b1;
        end else begin
          vacc_d  = vwork_q;
          y0_d    = dy_q;
          dy_d    = dy_q + $signed({1'b0, rows_q});
          state_d = WCSP_EMIT;
        end
      end
      WCSP_EMIT: begin
        if (hacc_q < {1'b0, fsrc_q.width}) begin
          state_d = WCSP_TAKE;
        end else if (r_q < rows_q) begin
          // unit factors give exactly one write per on-screen pixel; off-screen ones give none
          if (!vis) begin
            r_d = r_q + 1'b1;
          end else if (!fifo_full) begin
            push = 1'b1;
            r_d  = r_q + 1'b1;
          end
        end else begin
          r_d    = '0;
          hacc_d = hacc_q - {1'b0, fsrc_q.width};
          dx_d   = dx_q + 14'sh0001; // a one-bit signed literal would step left
        end
      end
      default: state_d = WCSP_TAKE;
    endcase
    // registered so IN_READY is a flop
    rdy_d = (state_d == WCSP_TAKE) && !(take && in_win);
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      state_q <= WCSP_TAKE;
      fsrc_q  <= '0;
      fdst_q  <= '0;
      sx_q    <= '0;
      sy_q    <= '0;
      pix_q   <= '0;
      hacc_q  <= '0;
      vacc_q  <= '0;
      vwork_q <= '0;
      rows_q  <= '0;
      r_q     <= '0;
      dx_q    <= '0;
      dy_q    <= '0;
      y0_q    <= '0;
      rdy_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      fsrc_q  <= fsrc_d;
      fdst_q  <= fdst_d;
      sx_q    <= sx_d;
      sy_q    <= sy_d;
      pix_q   <= pix_d;
      hacc_q  <= hacc_d;
      vacc_q  <= vacc_d;
      vwork_q <= vwork_d;
      rows_q  <= rows_d;
      r_q     <= r_d;
      dx_q    <= dx_d;
      dy_q    <= dy_d;
      y0_q    <= y0_d;
      rdy_q   <= rdy_d;
    end
  end

  assign IN_READY = rdy_q;

  // ----------------------------------------------------------------
  // two-entry output buffer: head drives the port, tail absorbs a stall
  // ----------------------------------------------------------------
  logic      head_v_q, head_v_d, tail_v_q, tail_v_d;
  wcsp_out_t head_q, head_d, tail_q, tail_d;
  logic      pop;

  assign fifo_full = tail_v_q;

  // push only when tail is free, so no word is ever dropped
  always_comb begin
    head_v_d = head_v_q;
    head_d   = head_q;
    tail_v_d = tail_v_q;
    tail_d   = tail_q;
    pop      = head_v_q && OUT_READY;
    if (pop) begin
      if (tail_v_q) begin
        head_d   = tail_q;
        tail_v_d = 1'b0;
      end else begin
        head_v_d = push;
        head_d   = push_pix;
      end
    end else if (push) begin
      if (!head_v_q) begin
        head_v_d = 1'b1;
        head_d   = push_pix;
      end else begin
        tail_v_d = 1'b1;
        tail_d   = push_pix;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
      head_q   <= '0;
      tail_q   <= '0;
    end else begin
      head_v_q <= head_v_d;
      tail_v_q <= tail_v_d;
      head_q   <= head_d;
      tail_q   <= tail_d;
    end
  end

  assign OUT_VALID = head_v_q;
  assign OUT_PIX   = head_q;

endmodule
`default_nettype wire

// ---- verif/wcsp_sink_model.sv ----
// display-side sink model for the window stage output stream
// assumes one clock; stall makes ready toggle every cycle
`timescale 1ns/1ps
`default_nettype none

module wcsp_sink_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic stall,
  output logic      ready
);
  // toggling ready forces the two-entry buffer to hold and refill
  always_ff @(posedge clk) begin
    ready <= rst ? 1'b0 : (stall ? ~ready : 1'b1);
  end
endmodule
`default_nettype wire

// ---- verif/wcsp_top_monitor.sv ----
// port checker for the window stage, bound to wcsp_top
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "wcsp_params.svh"

module wcsp_top_monitor (
  input wire logic                     REF_CLK,
  input wire logic                     SRST,
  input wire logic [`WCSP_COORD_W-1:0] SCREEN_W,
  input wire logic [`WCSP_COORD_W-1:0] SCREEN_H,
  input wire logic                     IN_VALID,
  input wire logic                     IN_READY,
  input wire logic                     OUT_VALID,
  input wire wcsp_pkg::wcsp_out_t      OUT_PIX,
  input wire logic                     OUT_READY
);
  import wcsp_pkg::*;
  logic seen_q;
  // set once any pixel was taken; no write may precede that
  always_ff @(posedge REF_CLK) begin
    seen_q <= SRST ? 1'b0 : (seen_q | (IN_VALID & IN_READY));
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  chk_out_held: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID) else $error("write dropped");
  chk_out_stable: assert property (OUT_VALID && !OUT_READY |=> $stable(OUT_PIX)) else $error("write changed");
  chk_x_visible: assert property (OUT_VALID |-> OUT_PIX.x < SCREEN_W) else $error("x off screen");
  chk_y_visible: assert property (OUT_VALID |-> OUT_PIX.y < SCREEN_H) else $error("y off screen");
  chk_no_spurious: assert property (OUT_VALID |-> seen_q) else $error("write with no input");
  chk_ready_release: assert property ($fell(SRST) |-> ##[0:1] IN_READY) else $error("ready late");
  chk_rst_valid: assert property (disable iff (1'b0) SRST |=> !OUT_VALID) else $error("valid in reset");
  chk_rst_ready: assert property (disable iff (1'b0) SRST |=> !IN_READY) else $error("ready in reset");
  chk_rst_pix: assert property (disable iff (1'b0) SRST |=> OUT_PIX == '0) else $error("pix in reset");
  cov_stall: cover property (OUT_VALID && !OUT_READY);
  cov_write: cover property (OUT_VALID && OUT_READY);
  cov_take: cover property (IN_VALID && IN_READY);
endmodule

bind wcsp_top wcsp_top_monitor i_wcsp_top_monitor (.*);
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the window crop, scale and place stage
// assumes the sink model beside it and the design package compiled first
`timescale 1ns/1ps
`default_nettype none
`include "wcsp_params.svh"

module tb_top;
  import wcsp_pkg::*;
  logic REF_CLK = 0, SRST = 1, set_s = 0, set_d = 0, in_valid = 0, stall = 0, in_ready;
  logic [1:0] sel = 0;
  logic [11:0] scr_w = 12'h500, scr_h = 12'h400;
  wcsp_src_rect_t src = '0;
  wcsp_dst_rect_t dst = '0;
  wcsp_pix_t in_pix = '0;
  logic out_valid, out_ready;
  wcsp_out_t out_pix;
  wcsp_out_t got[$], exp_q[$];
  int n_fail = 0, samples_checked = 0;

  always #20 REF_CLK = ~REF_CLK;
  wcsp_top i_wcsp_top (.REF_CLK(REF_CLK), .SRST(SRST), .SEL_INPUT(sel), .SET_SOURCE_WINDOW(set_s),
    .SRC_WIN_IN(src), .SET_DESTINATION_WINDOW(set_d), .DST_WIN_IN(dst), .SCREEN_W(scr_w),
    .SCREEN_H(scr_h), .IN_VALID(in_valid), .IN_PIX(in_pix), .IN_READY(in_ready),
    .OUT_VALID(out_valid), .OUT_PIX(out_pix), .OUT_READY(out_ready));
  wcsp_sink_model i_wcsp_sink_model (.clk(REF_CLK), .rst(SRST), .stall(stall), .ready(out_ready));

  // every accepted screen write lands in the queue
  always @(posedge REF_CLK) if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_pix);

  function automatic logic [23:0] pd(int x, int y);
    return 24'h0A_0000 + 24'((y << 8) + x);
  endfunction
  function automatic void ex(int x, int y, logic [23:0] d);
    exp_q.push_back('{12'(x), 12'(y), d});
  endfunction
  task automatic chk(string nm, logic [47:0] s, logic [47:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // both strobes in one cycle is legal and halves the set-up time
  task automatic set_win(int id, int sl, int st, int sw, int sh, int dl, int dt, int dw, int dh);
    @(negedge REF_CLK);
    sel = 2'(id); set_s = 1; set_d = 1;
    src = '{12'(sl), 12'(st), 12'(sw), 12'(sh)};
    dst = '{13'(dl), 13'(dt), 12'(dw), 12'(dh)};
    @(negedge REF_CLK);
    set_s = 0; set_d = 0;
  endtask
  // held until ready is seen high at a rising edge
  task automatic frame(int id, int w, int h);
    int k;
    for (int y = 0; y < h; y++) for (int x = 0; x < w; x++) begin
      @(negedge REF_CLK);
      in_valid = 1;
      in_pix = '{pd(x, y), x == 0 && y == 0, x == w - 1, 2'(id)};
      k = 0;
      do begin @(posedge REF_CLK); k++; end while (in_ready !== 1'b1 && k < 200);
      if (k >= 200) n_fail++;
    end
    @(negedge REF_CLK);
    in_valid = 0;
  endtask
  task automatic check_writes(string nm);
    for (int k = 0; k < 400 && got.size() < exp_q.size(); k++) @(posedge REF_CLK);
    repeat (20) @(posedge REF_CLK);
    chk({nm, " count"}, 48'(got.size()), 48'(exp_q.size()));
    foreach (exp_q[i]) chk(nm, (i < got.size()) ? got[i] : 48'h0, exp_q[i]);
    got.delete(); exp_q.delete();
  endtask

  // windows left at their reset values copy the picture one to one at the origin
  task automatic t_defaults();
    frame(1, 2, 2);
    ex(0, 0, pd(0, 0));
    ex(1, 0, pd(1, 0));
    ex(0, 1, pd(0, 1));
    ex(1, 1, pd(1, 1));
    check_writes("defaults");
  endtask
  task automatic t_crop();
    set_win(0, 1, 0, 2, 1, 5, 5, 2, 1);
    frame(0, 3, 2);
    ex(5, 5, pd(1, 0)); ex(6, 5, pd(2, 0));
    check_writes("crop");
  endtask
  task automatic t_scale();
    @(negedge REF_CLK);
    stall = 1;
    set_win(1, 0, 0, 1, 1, 0, 0, 2, 3);
    frame(1, 1, 1);
    for (int x = 0; x < 2; x++) for (int y = 0; y < 3; y++) ex(x, y, pd(0, 0));
    check_writes("scale");
    // a 2x2 source shrunk to one pixel keeps the last pixel of the block
    set_win(1, 0, 0, 2, 2, 0, 0, 1, 1);
    frame(1, 2, 2);
    ex(0, 0, pd(1, 1));
    check_writes("shrink");
    @(negedge REF_CLK);
    stall = 0;
  endtask
  task automatic t_clip();
    @(negedge REF_CLK); scr_w = 12'h004; scr_h = 12'h004;
    set_win(2, 0, 0, 2, 1, -1, -1, 2, 2);
    frame(2, 2, 1); ex(0, 0, pd(1, 0));
    check_writes("clip left");
    set_win(2, 0, 0, 2, 1, 3, 3, 2, 1);
    frame(2, 2, 1); ex(3, 3, pd(0, 0));
    check_writes("clip right");
    set_win(2, 0, 0, 2, 1, 2, 3, 2, 1);
    frame(2, 2, 1); ex(2, 3, pd(0, 0)); ex(3, 3, pd(1, 0));
    check_writes("back in view");
    @(negedge REF_CLK); scr_w = 12'h500; scr_h = 12'h400;
  endtask
  // a write to slot 3 must leave slot 0 untouched
  task automatic t_sel();
    set_win(3, 0, 0, 1, 1, 7, 7, 1, 1);
    frame(0, 3, 2); ex(5, 5, pd(1, 0)); ex(6, 5, pd(2, 0));
    check_writes("slot kept");
    frame(3, 3, 2); ex(7, 7, pd(0, 0));
    check_writes("slot used");
  endtask

  initial begin
    repeat (12) @(posedge REF_CLK);
    @(negedge REF_CLK); SRST = 0;
    t_defaults();
    t_crop();
    t_scale();
    t_clip();
    t_sel();
    wrap_up();
  end
  initial begin
    #(40 * 20000);
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
